// file: bcst_pkg.sv
// Purpose: Shared constants and types for the bulk/control split translator.
// Assumes: Packets arrive decoded.
// Notes: Buffer count default below.
//
// Notes on behaviour
// - Only one bulk/control split transaction is held per endpoint at a time.
// - Matching uses address and endpoint; bulk endpoints also compare direction.
// - Control endpoints match on address and endpoint only, never direction.
// - Match in pending or ready is a repeat; match in other status is fresh.
// - Scan from index 0; last old buffer wins without a match; else full.
// - Data timeout or bad data CRC after a start-split gives no handshake.
// - Start-split finding no space is answered NAK and nothing is stored.
// - Fresh start-split stores token and OUT data, goes pending, answers ACK.
// - Repeat start-split is answered ACK, its data dropped, buffer untouched.
// - Downstream errors retry locally; the third error records a stall result.
// - ACK, NAK or STALL downstream is never retried and is recorded as result.
// - Complete-split finding its buffer pending is answered NYET.
// - Complete-split with no matching buffer is answered STALL.
// - Finished downstream transaction saves result and IN data, pending to ready.
// - Complete-split answered from a ready buffer turns it old, result kept.
// - At least two transaction buffers, each with token info and result.
// - Every buffer leaves reset in old status, free for a start-split.
package bcst_pkg;

  localparam int ADDR_W = 7;
  localparam int EP_W = 4;
  localparam int DATA_W = 8;
  localparam int MAX_PKT = 64;
  localparam int OFS_W = 6;
  localparam int LEN_W = 7;
  localparam int NUM_BUF_DEF = 2;
  localparam int FIFO_DEPTH = 32;
  localparam int ERR_W = 2;
  localparam logic [ERR_W-1:0] ERR_LIMIT = 2'h3;
  localparam logic [ERR_W-1:0] ERR_STEP = 2'h1;
  localparam logic [LEN_W-1:0] LEN_ONE = 7'h01;
  localparam logic [LEN_W-1:0] LEN_MAX = 7'h40;

  // Transaction status of one buffer
  typedef enum logic [1:0] {ST_OLD, ST_PENDING, ST_READY} bcst_status_t;

  // Answer sent upstream to the host controller
  typedef enum logic [2:0] {HSK_ACK, HSK_NAK, HSK_NYET, HSK_STALL, HSK_DATA} bcst_hsk_t;

  // Result reported by the downstream bus engine
  typedef enum logic [1:0] {RES_ACK, RES_NAK, RES_STALL, RES_ERR} bcst_res_t;

  // Outcome of the buffer lookup
  typedef enum logic [1:0] {LK_FULL, LK_FRESH, LK_REPEAT} bcst_lookup_t;

  localparam bcst_status_t STATUS_RST = ST_OLD;
  localparam bcst_res_t RESULT_RST = RES_NAK;

endpackage : bcst_pkg

// file: bcst_stream_if.sv
// Purpose: Valid/ready byte stream between the translator and its FIFO.
// Assumes: Single clock domain.
// Notes: Data moves when valid and ready are both high.
`timescale 1ns/100ps
interface bcst_stream_if #(parameter int WIDTH = 8);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;

  // Producer and consumer views
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : bcst_stream_if

// file: bcst_fifo.sv
// Purpose: OUT payload FIFO.
// Assumes: DEPTH is a power of two.
// Notes: Full and empty come from wrap-bit pointers.
`timescale 1ns/100ps
module bcst_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic clk_i,
  input wire logic rst_i,
  bcst_stream_if.snk wr,
  bcst_stream_if.src rd
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [PW:0] wr_ptr_r;
  logic [PW:0] rd_ptr_r;
  wire full = (wr_ptr_r[PW] != rd_ptr_r[PW]) && (wr_ptr_r[PW-1:0] == rd_ptr_r[PW-1:0]);
  wire empty = (wr_ptr_r == rd_ptr_r);
  wire do_wr = wr.valid && !full;
  wire do_rd = rd.ready && !empty;

  // Handshake outputs
  assign wr.ready = !full;
  assign rd.valid = !empty;
  assign rd.data = store[rd_ptr_r[PW-1:0]];

  // Pointer update
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (do_wr) wr_ptr_r <= wr_ptr_r + 1'b1;
      if (do_rd) rd_ptr_r <= rd_ptr_r + 1'b1;
    end
  end

  // Storage write
  always_ff @(posedge clk_i) begin
    if (do_wr) store[wr_ptr_r[PW-1:0]] <= wr.data;
  end
endmodule : bcst_fifo

// file: bcst_translator.sv
// Purpose: Bulk/control split handling of a transaction translator.
// Assumes: Tokens, data packets and downstream results arrive decoded.
// Notes: High-speed handler and downstream engine share the buffers.
`timescale 1ns/100ps
module bcst_translator #(
  parameter int NUM_BUF = bcst_pkg::NUM_BUF_DEF
) (
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  input wire logic HS_TOK_VALID_I,
  input wire logic HS_COMPLETE_I,
  input wire logic [bcst_pkg::ADDR_W-1:0] HS_DEV_ADDR_I,
  input wire logic [bcst_pkg::EP_W-1:0] HS_ENDPT_I,
  input wire logic HS_DIR_IN_I,
  input wire logic HS_EP_CTRL_I,
  input wire logic HS_RX_VALID_I,
  input wire logic [bcst_pkg::DATA_W-1:0] HS_RX_DATA_I,
  input wire logic HS_RX_END_I,
  input wire logic HS_RX_CRC_OK_I,
  input wire logic HS_TIMEOUT_I,
  output logic HS_HSK_VALID_O,
  output bcst_pkg::bcst_hsk_t HS_HSK_CODE_O,
  output logic HS_TX_VALID_O,
  output logic [bcst_pkg::DATA_W-1:0] HS_TX_DATA_O,
  output logic HS_TX_LAST_O,
  input wire logic HS_TX_READY_I,
  output logic HS_BUSY_O,
  output logic DS_REQ_VALID_O,
  input wire logic DS_REQ_READY_I,
  output logic [bcst_pkg::ADDR_W-1:0] DS_DEV_ADDR_O,
  output logic [bcst_pkg::EP_W-1:0] DS_ENDPT_O,
  output logic DS_DIR_IN_O,
  output logic DS_EP_CTRL_O,
  output logic [bcst_pkg::LEN_W-1:0] DS_LEN_O,
  output logic DS_OUT_VALID_O,
  output logic [bcst_pkg::DATA_W-1:0] DS_OUT_DATA_O,
  input wire logic DS_OUT_READY_I,
  input wire logic DS_IN_VALID_I,
  input wire logic [bcst_pkg::DATA_W-1:0] DS_IN_DATA_I,
  input wire logic DS_RES_VALID_I,
  input wire bcst_pkg::bcst_res_t DS_RES_CODE_I
);
  import bcst_pkg::*;

  localparam int IDX_W = (NUM_BUF > 1) ? $clog2(NUM_BUF) : 1;
  localparam int MEM_W = IDX_W + OFS_W;

  typedef enum {HS_IDLE, HS_RX, HS_TX} bcst_hs_state_t;
  typedef enum {DS_IDLE, DS_REQ, DS_FILL, DS_WAIT} bcst_ds_state_t;

  ////////////////////////////////////////////////////////////////////////////////
  // Buffer storage, one entry per transaction
  bcst_status_t status_r [NUM_BUF];
  logic used_r [NUM_BUF];
  logic [ADDR_W-1:0] dev_r [NUM_BUF];
  logic [EP_W-1:0] ep_r [NUM_BUF];
  logic dir_r [NUM_BUF];
  logic ctrl_r [NUM_BUF];
  logic [LEN_W-1:0] len_r [NUM_BUF];
  bcst_res_t res_r [NUM_BUF];
  logic [DATA_W-1:0] mem [NUM_BUF * MAX_PKT];

  bcst_hs_state_t hs_state_r;
  bcst_ds_state_t ds_state_r;
  bcst_lookup_t kind_r;
  logic [IDX_W-1:0] hs_idx_r;
  logic tok_dir_r;
  logic tok_ctrl_r;
  logic [ADDR_W-1:0] tok_dev_r;
  logic [EP_W-1:0] tok_ep_r;
  logic [LEN_W-1:0] rx_cnt_r;
  logic [LEN_W-1:0] tx_ptr_r;
  logic hsk_valid_r;
  bcst_hsk_t hsk_code_r;
  logic [DATA_W-1:0] tx_data_r;
  logic [IDX_W-1:0] ds_idx_r;
  logic [ERR_W-1:0] err_cnt_r;
  logic [LEN_W-1:0] fill_ptr_r;
  logic [LEN_W-1:0] in_cnt_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Buffer lookup, all buffers in one cycle
  bcst_lookup_t lookup_result;
  logic [IDX_W-1:0] lookup_idx;
  logic lookup_hit;
  logic [NUM_BUF-1:0] buf_match;

  always_comb begin
    lookup_result = LK_FULL;
    lookup_idx = '0;
    lookup_hit = 1'b0;
    for (int i = 0; i < NUM_BUF; i++) begin
      buf_match[i] = used_r[i] && (ep_r[i] == HS_ENDPT_I) && (dev_r[i] == HS_DEV_ADDR_I)
        && (HS_EP_CTRL_I || (dir_r[i] == HS_DIR_IN_I));
      if (!lookup_hit) begin
        if (buf_match[i]) begin
          lookup_result = (status_r[i] == ST_PENDING || status_r[i] == ST_READY)
            ? LK_REPEAT : LK_FRESH;
          lookup_idx = IDX_W'(i);
          lookup_hit = 1'b1;
        end else if (status_r[i] == ST_OLD) begin
          lookup_result = LK_FRESH;
          lookup_idx = IDX_W'(i);
        end
      end
    end
  end

  // Named views of the lookup outcome
  wire lookup_fresh_request = (lookup_result == LK_FRESH);
  wire lookup_repeat_request = (lookup_result == LK_REPEAT);
  wire lookup_full = (lookup_result == LK_FULL);

  ////////////////////////////////////////////////////////////////////////////////
  // High-speed side decode
  wire tok_take = (hs_state_r == HS_IDLE) && HS_TOK_VALID_I;
  wire ss_in_take = tok_take && !HS_COMPLETE_I && HS_DIR_IN_I;
  wire ss_out_take = tok_take && !HS_COMPLETE_I && !HS_DIR_IN_I;
  wire cs_take = tok_take && HS_COMPLETE_I;
  wire rx_byte = (hs_state_r == HS_RX) && HS_RX_VALID_I;
  wire rx_good = (hs_state_r == HS_RX) && HS_RX_END_I && HS_RX_CRC_OK_I;
  wire rx_abort = (hs_state_r == HS_RX) && (HS_TIMEOUT_I || (HS_RX_END_I && !HS_RX_CRC_OK_I));
  wire accept_transition = (ss_in_take && lookup_fresh_request)
    || (rx_good && kind_r == LK_FRESH);
  wire repeat_accept_transition = (ss_in_take && lookup_repeat_request)
    || (rx_good && kind_r == LK_REPEAT);
  wire refuse_transition = (ss_in_take && lookup_full) || (rx_good && kind_r == LK_FULL);
  wire token_timeout_transition = rx_abort;
  wire [IDX_W-1:0] commit_idx = ss_in_take ? lookup_idx : hs_idx_r;
  wire cs_pending = cs_take && lookup_hit && (status_r[lookup_idx] == ST_PENDING);
  wire cs_done = cs_take && lookup_hit && !cs_pending;
  wire cs_data = cs_done && dir_r[lookup_idx] && (res_r[lookup_idx] == RES_ACK);
  wire cs_stream = cs_data && (len_r[lookup_idx] != '0);
  wire tx_fire = (hs_state_r == HS_TX) && HS_TX_READY_I;
  wire tx_last = (tx_ptr_r + LEN_ONE) == len_r[hs_idx_r];
  wire rx_store = rx_byte && (kind_r == LK_FRESH) && (rx_cnt_r < LEN_MAX);

  // Stored result mapped to a handshake
  bcst_hsk_t cs_code;
  always_comb begin
    case (res_r[lookup_idx])
      RES_ACK: cs_code = dir_r[lookup_idx] ? HSK_DATA : HSK_ACK;
      RES_NAK: cs_code = HSK_NAK;
      default: cs_code = HSK_STALL;
    endcase
  end

  // High-speed handler sequencing
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      hs_state_r <= HS_IDLE;
    end else begin
      case (hs_state_r)
        HS_IDLE: begin
          if (ss_out_take) hs_state_r <= HS_RX;
          else if (cs_stream) hs_state_r <= HS_TX;
        end
        HS_RX: if (rx_good || rx_abort) hs_state_r <= HS_IDLE;
        HS_TX: if (tx_fire && tx_last) hs_state_r <= HS_IDLE;
        default: hs_state_r <= HS_IDLE;
      endcase
    end
  end

  // Token capture and byte counters
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      kind_r <= LK_FULL;
      hs_idx_r <= '0;
      tok_dir_r <= 1'b0;
      tok_ctrl_r <= 1'b0;
      tok_dev_r <= '0;
      tok_ep_r <= '0;
      rx_cnt_r <= '0;
      tx_ptr_r <= '0;
    end else begin
      if (tok_take) begin
        kind_r <= lookup_result;
        hs_idx_r <= lookup_idx;
        tok_dir_r <= HS_DIR_IN_I;
        tok_ctrl_r <= HS_EP_CTRL_I;
        tok_dev_r <= HS_DEV_ADDR_I;
        tok_ep_r <= HS_ENDPT_I;
        rx_cnt_r <= '0;
        tx_ptr_r <= '0;
      end
      if (rx_store) rx_cnt_r <= rx_cnt_r + LEN_ONE;
      if (tx_fire) tx_ptr_r <= tx_ptr_r + LEN_ONE;
    end
  end

  // Handshake and IN data towards the host
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      hsk_valid_r <= 1'b0;
      hsk_code_r <= HSK_NAK;
      tx_data_r <= '0;
    end else begin
      hsk_valid_r <= accept_transition || repeat_accept_transition || refuse_transition
        || cs_take;
      if (accept_transition || repeat_accept_transition) hsk_code_r <= HSK_ACK;
      else if (refuse_transition) hsk_code_r <= HSK_NAK;
      else if (cs_pending) hsk_code_r <= HSK_NYET;
      else if (cs_done) hsk_code_r <= cs_code;
      else if (cs_take) hsk_code_r <= HSK_STALL;
      if (cs_stream) tx_data_r <= mem[{lookup_idx, {OFS_W{1'b0}}}];
      else if (tx_fire && !tx_last) tx_data_r <= mem[{hs_idx_r, tx_ptr_r[OFS_W-1:0] + 1'b1}];
    end
  end

  assign HS_HSK_VALID_O = hsk_valid_r;
  assign HS_HSK_CODE_O = hsk_code_r;
  assign HS_TX_VALID_O = (hs_state_r == HS_TX);
  assign HS_TX_DATA_O = tx_data_r;
  assign HS_TX_LAST_O = (hs_state_r == HS_TX) && tx_last;
  assign HS_BUSY_O = (hs_state_r != HS_IDLE);

  ////////////////////////////////////////////////////////////////////////////////
  // Downstream engine: lowest-index pending buffer first
  logic pend_found;
  logic [IDX_W-1:0] pend_idx;
  always_comb begin
    pend_found = 1'b0;
    pend_idx = '0;
    for (int i = NUM_BUF - 1; i >= 0; i--) begin
      if (status_r[i] == ST_PENDING) begin
        pend_found = 1'b1;
        pend_idx = IDX_W'(i);
      end
    end
  end

  bcst_stream_if #(.WIDTH(DATA_W)) fifo_wr ();
  bcst_stream_if #(.WIDTH(DATA_W)) fifo_rd ();

  wire ds_req_fire = (ds_state_r == DS_REQ) && DS_REQ_READY_I;
  wire ds_push = (ds_state_r == DS_FILL) && (fill_ptr_r != len_r[ds_idx_r]);
  wire ds_fill_done = (ds_state_r == DS_FILL) && (fill_ptr_r == len_r[ds_idx_r]);
  wire ds_res = (ds_state_r == DS_WAIT) && DS_RES_VALID_I;
  wire ds_err = ds_res && (DS_RES_CODE_I == RES_ERR);
  wire ds_give_up = ds_err && ((err_cnt_r + ERR_STEP) == ERR_LIMIT);
  wire ds_retry = ds_err && !ds_give_up;
  wire ds_finish = ds_res && !ds_retry;
  wire ds_in_store = (ds_state_r == DS_WAIT) && DS_IN_VALID_I && (in_cnt_r < LEN_MAX);
  wire bcst_res_t ds_result = ds_give_up ? RES_STALL : DS_RES_CODE_I;

  assign fifo_wr.valid = ds_push;
  assign fifo_wr.data = mem[{ds_idx_r, fill_ptr_r[OFS_W-1:0]}];
  assign fifo_rd.ready = DS_OUT_READY_I;

  // Downstream sequencing with local retry
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      ds_state_r <= DS_IDLE;
      ds_idx_r <= '0;
      err_cnt_r <= '0;
      fill_ptr_r <= '0;
      in_cnt_r <= '0;
    end else begin
      case (ds_state_r)
        DS_IDLE: if (pend_found) begin
          ds_state_r <= DS_REQ;
          ds_idx_r <= pend_idx;
          err_cnt_r <= '0;
        end
        DS_REQ: if (ds_req_fire) begin
          ds_state_r <= dir_r[ds_idx_r] ? DS_WAIT : DS_FILL;
          fill_ptr_r <= '0;
          in_cnt_r <= '0;
        end
        DS_FILL: begin
          if (ds_push && fifo_wr.ready) fill_ptr_r <= fill_ptr_r + LEN_ONE;
          if (ds_fill_done) ds_state_r <= DS_WAIT;
        end
        DS_WAIT: begin
          if (ds_in_store) in_cnt_r <= in_cnt_r + LEN_ONE;
          if (ds_retry) begin
            err_cnt_r <= err_cnt_r + ERR_STEP;
            ds_state_r <= DS_REQ;
          end else if (ds_finish) begin
            ds_state_r <= DS_IDLE;
          end
        end
        default: ds_state_r <= DS_IDLE;
      endcase
    end
  end

  assign DS_REQ_VALID_O = (ds_state_r == DS_REQ);
  assign DS_DEV_ADDR_O = dev_r[ds_idx_r];
  assign DS_ENDPT_O = ep_r[ds_idx_r];
  assign DS_DIR_IN_O = dir_r[ds_idx_r];
  assign DS_EP_CTRL_O = ctrl_r[ds_idx_r];
  assign DS_LEN_O = len_r[ds_idx_r];
  assign DS_OUT_VALID_O = fifo_rd.valid;
  assign DS_OUT_DATA_O = fifo_rd.data;

  bcst_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_out_fifo (
    .clk_i(CLK_SYS_I),
    .rst_i(RST_I),
    .wr(fifo_wr),
    .rd(fifo_rd)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Buffer state updates from both handlers; they never touch one entry together
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      for (int i = 0; i < NUM_BUF; i++) begin
        status_r[i] <= STATUS_RST;
        used_r[i] <= 1'b0;
        dev_r[i] <= '0;
        ep_r[i] <= '0;
        dir_r[i] <= 1'b0;
        ctrl_r[i] <= 1'b0;
        len_r[i] <= '0;
        res_r[i] <= RESULT_RST;
      end
    end else begin
      if (accept_transition && ss_in_take) begin
        status_r[commit_idx] <= ST_PENDING;
        used_r[commit_idx] <= 1'b1;
        dev_r[commit_idx] <= HS_DEV_ADDR_I;
        ep_r[commit_idx] <= HS_ENDPT_I;
        dir_r[commit_idx] <= HS_DIR_IN_I;
        ctrl_r[commit_idx] <= HS_EP_CTRL_I;
        len_r[commit_idx] <= '0;
      end else if (accept_transition) begin
        status_r[commit_idx] <= ST_PENDING;
        used_r[commit_idx] <= 1'b1;
        dev_r[commit_idx] <= tok_dev_r;
        ep_r[commit_idx] <= tok_ep_r;
        dir_r[commit_idx] <= tok_dir_r;
        ctrl_r[commit_idx] <= tok_ctrl_r;
        len_r[commit_idx] <= rx_cnt_r;
      end
      if (cs_done && status_r[lookup_idx] == ST_READY) begin
        status_r[lookup_idx] <= ST_OLD;
      end
      if (ds_finish) begin
        status_r[ds_idx_r] <= ST_READY;
        res_r[ds_idx_r] <= ds_result;
        if (dir_r[ds_idx_r]) len_r[ds_idx_r] <= in_cnt_r;
      end
    end
  end

  // Payload memory, OUT from host, IN from downstream
  always_ff @(posedge CLK_SYS_I) begin
    if (rx_store) mem[{hs_idx_r, rx_cnt_r[OFS_W-1:0]}] <= HS_RX_DATA_I;
    if (ds_in_store) mem[{ds_idx_r, in_cnt_r[OFS_W-1:0]}] <= DS_IN_DATA_I;
  end

endmodule : bcst_translator

// file: bcst_translator_asserts.sv
// Purpose: Port checks of the split translator.
// Assumes: One clock domain, reset active high.
// Notes: Bound in the testbench top file.
`timescale 1ns/100ps
module bcst_translator_asserts (
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  input wire logic HS_TOK_VALID_I,
  input wire logic HS_COMPLETE_I,
  input wire logic HS_DIR_IN_I,
  input wire logic HS_RX_END_I,
  input wire logic HS_RX_CRC_OK_I,
  input wire logic HS_TIMEOUT_I,
  input wire logic HS_HSK_VALID_O,
  input wire bcst_pkg::bcst_hsk_t HS_HSK_CODE_O,
  input wire logic HS_TX_VALID_O,
  input wire logic [bcst_pkg::DATA_W-1:0] HS_TX_DATA_O,
  input wire logic HS_TX_READY_I,
  input wire logic HS_BUSY_O,
  input wire logic DS_REQ_VALID_O,
  input wire logic DS_REQ_READY_I,
  input wire logic [bcst_pkg::EP_W-1:0] DS_ENDPT_O,
  input wire logic [bcst_pkg::LEN_W-1:0] DS_LEN_O
);
  import bcst_pkg::*;
  ////////////////////////////////////////////////////////////////////////////////
  // One clock, checks off during reset
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);
  // Token taken; answer pulse
  sequence s_take;
    HS_TOK_VALID_I && !HS_BUSY_O;
  endsequence
  sequence s_hsk(ok);
    HS_HSK_VALID_O && ok;
  endsequence
  AST_OUT_SS_QUIET: assert property (
    s_take ##0 (!HS_COMPLETE_I && !HS_DIR_IN_I) |=> HS_BUSY_O && !HS_HSK_VALID_O)
    else $error("early OUT answer");
  AST_IN_SS_ANSWER: assert property (
    s_take ##0 (!HS_COMPLETE_I && HS_DIR_IN_I)
    |=> s_hsk(HS_HSK_CODE_O inside {HSK_ACK, HSK_NAK}) ##1 !HS_HSK_VALID_O)
    else $error("bad IN answer");
  AST_CS_ANSWER: assert property (
    s_take ##0 HS_COMPLETE_I |=> s_hsk(1'b1)) else $error("no CS answer");
  AST_GOOD_END: assert property (
    HS_BUSY_O && HS_RX_END_I && HS_RX_CRC_OK_I
    |=> s_hsk(HS_HSK_CODE_O inside {HSK_ACK, HSK_NAK})) else $error("no OUT answer");
  AST_BAD_CRC: assert property (
    HS_BUSY_O && HS_RX_END_I && !HS_RX_CRC_OK_I |=> !HS_HSK_VALID_O [*2])
    else $error("bad CRC answered");
  AST_TIMEOUT: assert property (
    HS_BUSY_O && HS_TIMEOUT_I |=> !HS_HSK_VALID_O ##1 !HS_BUSY_O)
    else $error("timeout answered");
  AST_REQ_HOLD: assert property (
    DS_REQ_VALID_O && !DS_REQ_READY_I
    |=> DS_REQ_VALID_O && $stable(DS_LEN_O) && $stable(DS_ENDPT_O))
    else $error("request changed");
  AST_TX_HOLD: assert property (
    HS_TX_VALID_O && !HS_TX_READY_I |=> HS_TX_VALID_O && $stable(HS_TX_DATA_O))
    else $error("beat changed");
endmodule : bcst_translator_asserts

// file: bcst_host_model.sv
// Purpose: Host controller issuing split tokens and OUT packets.
// Assumes: Drives on the falling edge.
// Notes: Lost answers are retried up to the error limit.
`timescale 1ns/100ps
module bcst_host_model (
  input wire logic clk_i,
  input wire logic hsk_v_i,
  input wire bcst_pkg::bcst_hsk_t hsk_c_i,
  input wire logic tx_v_i,
  input wire logic [bcst_pkg::DATA_W-1:0] tx_d_i,
  input wire logic tx_last_i,
  output logic tx_rdy_o,
  output logic tok_o,
  output logic cmp_o,
  output logic [bcst_pkg::ADDR_W-1:0] adr_o,
  output logic [bcst_pkg::EP_W-1:0] ep_o,
  output logic din_o,
  output logic ctl_o,
  output logic rx_v_o,
  output logic [bcst_pkg::DATA_W-1:0] rx_d_o,
  output logic end_o,
  output logic crc_o,
  output logic tout_o
);
  import bcst_pkg::*;
  logic seen;
  bcst_hsk_t code_r;
  int err_cnt;
  int last_at;
  logic [7:0] txb[$];
  ////////////////////////////////////////////////////////////////////////////////
  // Idle lines
  initial begin
    {tok_o, cmp_o, adr_o, ep_o, din_o, ctl_o, rx_v_o, rx_d_o, end_o, crc_o, tout_o} = '0;
    tx_rdy_o = 1'b0;
    seen = 1'b0;
    err_cnt = 0;
    last_at = -1;
  end
  // Catch answers and read beats
  always @(posedge clk_i) begin
    if (hsk_v_i) begin
      seen <= 1'b1;
      code_r <= hsk_c_i;
    end
    if (tx_v_i && tx_rdy_o) begin
      if (tx_last_i) last_at = txb.size();
      txb.push_back(tx_d_i);
    end
  end
  always @(negedge clk_i) tx_rdy_o <= ~tx_rdy_o;
  // One split; nb<0: data packet never comes
  task automatic split(input logic c, input logic [6:0] a, input logic [3:0] e, input logic d,
    input logic t, input int nb, input logic ok, input int tries,
    output bcst_hsk_t code, output logic got);
    do begin
      seen = 1'b0;
      @(negedge clk_i);
      {tok_o, cmp_o, adr_o, ep_o, din_o, ctl_o} <= {1'b1, c, a, e, d, t};
      @(negedge clk_i);
      tok_o <= 1'b0;
      for (int i = 0; i < nb; i++) begin
        rx_v_o <= 1'b1;
        rx_d_o <= 8'h30 + 8'(i);
        @(negedge clk_i);
      end
      rx_v_o <= 1'b0;
      rx_d_o <= ~rx_d_o;
      if (!c && !d) begin
        end_o <= (nb >= 0);
        crc_o <= ok;
        tout_o <= (nb < 0);
        @(negedge clk_i);
        {end_o, tout_o} <= 2'b00;
      end
      for (int w = 0; w < 6 && !seen; w++) @(negedge clk_i);
      got = seen;
      code = code_r;
      if (!got) err_cnt++;
      else if (code != HSK_NAK) err_cnt = 0;
    end while (!got && err_cnt < tries);
  endtask : split
endmodule : bcst_host_model

// file: bcst_translator_tb.sv
// Purpose: Bench of the split translator.
// Assumes: Two buffers; downstream answered by the bench.
// Notes: Ends through give_verdict.
`timescale 1ns/100ps
module bcst_translator_tb;
  import bcst_pkg::*;
  logic clk, rst, hs_tok, hs_cmp, hs_din, hs_ctl, rx_v, rx_end, crc_ok, tout, hsk_v, tx_v;
  logic tx_last, tx_rdy, busy, req_v, req_rdy, ds_ov, ds_ordy, ds_iv, res_v, got;
  logic [ADDR_W-1:0] hs_adr;
  logic [EP_W-1:0] hs_ep, ds_ep;
  logic [DATA_W-1:0] rx_d, tx_d, ds_od, ds_id;
  logic [LEN_W-1:0] ds_len;
  bcst_hsk_t hsk_c, code;
  bcst_res_t res_c;
  int n_errors, checks_done, nreq, nres, ocnt;
  ////////////////////////////////////////////////////////////////////////////////
  bcst_translator #(.NUM_BUF(2)) bcst_translator_inst (
    .CLK_SYS_I(clk), .RST_I(rst), .HS_TOK_VALID_I(hs_tok), .HS_COMPLETE_I(hs_cmp),
    .HS_DEV_ADDR_I(hs_adr), .HS_ENDPT_I(hs_ep), .HS_DIR_IN_I(hs_din), .HS_EP_CTRL_I(hs_ctl),
    .HS_RX_VALID_I(rx_v), .HS_RX_DATA_I(rx_d), .HS_RX_END_I(rx_end), .HS_RX_CRC_OK_I(crc_ok),
    .HS_TIMEOUT_I(tout), .HS_HSK_VALID_O(hsk_v), .HS_HSK_CODE_O(hsk_c), .HS_TX_VALID_O(tx_v),
    .HS_TX_DATA_O(tx_d), .HS_TX_LAST_O(tx_last), .HS_TX_READY_I(tx_rdy), .HS_BUSY_O(busy),
    .DS_REQ_VALID_O(req_v), .DS_REQ_READY_I(req_rdy), .DS_DEV_ADDR_O(), .DS_ENDPT_O(ds_ep),
    .DS_DIR_IN_O(), .DS_EP_CTRL_O(), .DS_LEN_O(ds_len), .DS_OUT_VALID_O(ds_ov),
    .DS_OUT_DATA_O(ds_od), .DS_OUT_READY_I(ds_ordy), .DS_IN_VALID_I(ds_iv), .DS_IN_DATA_I(ds_id),
    .DS_RES_VALID_I(res_v), .DS_RES_CODE_I(res_c));
  bcst_host_model bcst_host_model_inst (
    .clk_i(clk), .hsk_v_i(hsk_v), .hsk_c_i(hsk_c), .tx_v_i(tx_v), .tx_d_i(tx_d),
    .tx_last_i(tx_last), .tx_rdy_o(tx_rdy), .tok_o(hs_tok), .cmp_o(hs_cmp), .adr_o(hs_adr),
    .ep_o(hs_ep), .din_o(hs_din), .ctl_o(hs_ctl), .rx_v_o(rx_v), .rx_d_o(rx_d),
    .end_o(rx_end), .crc_o(crc_ok), .tout_o(tout));
  // Clock and downstream counters
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(negedge clk) req_rdy <= ~req_rdy;
  always @(posedge clk) begin
    if (req_v && req_rdy) begin
      nreq++;
      ocnt = 0;
    end
    if (ds_ov && ds_ordy) begin
      chk(ds_od, 8'h30 + 8'(ocnt));
      ocnt++;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: %h vs %h", $time, seen, exp);
    end
  endtask : chk
  task automatic give_verdict;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  task automatic tmo(input int w);
    if (w >= 400) begin
      n_errors++;
      give_verdict();
    end
  endtask : tmo
  // Host transfer; ff: no answer
  task automatic hs(input logic c, input logic [6:0] a, input logic [3:0] e, input logic d,
    input logic t, input int nb, input logic ok, input logic [7:0] exp);
    bcst_host_model_inst.split(c, a, e, d, t, nb, ok, (exp == 8'hff) ? 1 : 3, code, got);
    chk(got ? 8'(code) : 8'hff, exp);
  endtask : hs
  // Downstream partner
  task automatic ds_fin(input bcst_res_t r, input int nin, input int len, input logic [3:0] e);
    int w;
    for (w = 0; w < 400 && nreq <= nres; w++) @(negedge clk);
    tmo(w);
    chk(8'(ds_ep), 8'(e));
    if (len >= 0) begin
      chk(8'(ds_len), 8'(len));
      for (w = 0; w < 400 && ocnt < len; w++) @(negedge clk);
      tmo(w);
    end
    repeat (2) @(negedge clk);
    for (int i = 0; i < nin; i++) begin
      ds_iv <= 1'b1;
      ds_id <= 8'ha0 + 8'(i);
      @(negedge clk);
    end
    ds_iv <= 1'b0;
    ds_id <= ~ds_id;
    res_c <= r;
    res_v <= 1'b1;
    nres++;
    @(negedge clk);
    res_v <= 1'b0;
  endtask : ds_fin
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk({hsk_v, busy, req_v, ds_ov, tx_v}, 8'h00);
    chk(8'(hsk_c), 8'(HSK_NAK));
    $display("reset done");
  endtask : t_reset
  // FIFO stalled, buffers pending
  task automatic t_start;
    ds_ordy <= 1'b0;
    hs(0, 7'h05, 4'h1, 0, 0, 4, 0, 8'hff);
    hs(0, 7'h05, 4'h1, 0, 0, -1, 1, 8'hff);
    hs(0, 7'h05, 4'h1, 0, 0, 40, 1, 8'(HSK_ACK));
    hs(0, 7'h05, 4'h1, 0, 0, 40, 1, 8'(HSK_ACK));
    hs(1, 7'h05, 4'h1, 0, 0, 0, 1, 8'(HSK_NYET));
    hs(1, 7'h05, 4'h1, 1, 0, 0, 1, 8'(HSK_STALL));
    hs(0, 7'h06, 4'h0, 1, 1, 0, 1, 8'(HSK_ACK));
    hs(1, 7'h06, 4'h0, 0, 1, 0, 1, 8'(HSK_NYET));
    hs(0, 7'h07, 4'h2, 1, 0, 0, 1, 8'(HSK_NAK));
    $display("start done");
  endtask : t_start
  // Local retry, then reuse
  task automatic t_errors;
    ds_ordy <= 1'b1;
    repeat (3) ds_fin(RES_ERR, 0, 40, 4'h1);
    hs(1, 7'h05, 4'h1, 0, 0, 0, 1, 8'(HSK_STALL));
    hs(1, 7'h05, 4'h1, 0, 0, 0, 1, 8'(HSK_STALL));
    hs(0, 7'h07, 4'h2, 1, 0, 0, 1, 8'(HSK_ACK));
    $display("retry done");
  endtask : t_errors
  // IN data on complete-split
  task automatic t_in_data;
    int w;
    bcst_host_model_inst.txb.delete();
    ds_fin(RES_ACK, 3, -1, 4'h0);
    hs(1, 7'h06, 4'h0, 1, 1, 0, 1, 8'(HSK_DATA));
    for (w = 0; w < 400 && bcst_host_model_inst.txb.size() < 3; w++) @(negedge clk);
    tmo(w);
    for (int i = 0; i < 3; i++) chk(bcst_host_model_inst.txb[i], 8'ha0 + 8'(i));
    chk(8'(bcst_host_model_inst.last_at), 8'h02);
    $display("IN done");
  endtask : t_in_data
  // NAK is final
  task automatic t_nak;
    ds_fin(RES_NAK, 0, -1, 4'h2);
    hs(1, 7'h07, 4'h2, 1, 0, 0, 1, 8'(HSK_NAK));
    repeat (20) @(negedge clk);
    chk(8'(nreq), 8'(nres));
    $display("NAK done");
  endtask : t_nak
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst, n_errors, checks_done, nreq, nres, ocnt} = {1'b1, 160'h0};
    {ds_ordy, ds_iv, res_v, req_rdy, ds_id} = '0;
    res_c = RES_ACK;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_start();
    t_errors();
    t_in_data();
    t_nak();
    give_verdict();
  end
endmodule : bcst_translator_tb

bind bcst_translator bcst_translator_asserts bcst_translator_asserts_inst (
  .CLK_SYS_I, .RST_I, .HS_TOK_VALID_I, .HS_COMPLETE_I, .HS_DIR_IN_I, .HS_RX_END_I,
  .HS_RX_CRC_OK_I, .HS_TIMEOUT_I, .HS_HSK_VALID_O, .HS_HSK_CODE_O, .HS_TX_VALID_O,
  .HS_TX_DATA_O, .HS_TX_READY_I, .HS_BUSY_O, .DS_REQ_VALID_O, .DS_REQ_READY_I,
  .DS_ENDPT_O, .DS_LEN_O);
